/* File: rsw_reset_ctl.sv */
// reset sources, watchdog and clock monitor with axi4-lite registers
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rsw_params.svh"

// Notes on behaviour
// - any reset holds cpu, loads start vector
// - power-on holds reset 4064 bus ticks
// - pin low after delay keeps reset
// - pin and power-on share one vector
// - drive reset pin low four ticks
// - sample pin two ticks after release
// - disable bit takes effect after reset
// - special modes start watchdog inhibited
// - timebase E over 2^15 times factor
// - rate select resets to zero
// - rate writable once, first 64 ticks, in normal mode; any time in special mode
// - 55 then AA clears watchdog
// - other accesses allowed between both writes
// - unserviced watchdog timeout forces reset
// - clock monitor resets on missing clock
// - fail below 10 kHz, pass 200 kHz
// - watchdog stops when clock stops
// - stop with monitor enabled resets
// - vectors per cause, special uses BFxx
// - monitor enable read/write, reset clears
// - disable bit 0 enables watchdog
module rsw_reset_ctl #(
    parameter int WD_BASE = `RSW_WD_BASE
) (
    // clock and power-on reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // reset pin, open drain
    input  wire logic              rst_pin_i,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe,
    // cpu side
    input  wire logic              special_mode,
    input  wire logic              stop_mode,
    input  wire logic              clock_fail,
    output logic                   cpu_reset_n,
    output logic [15:0]            start_vector,
    // register bus
    input  wire rsw_pkg::rsw_axi_req_s axi_req,
    output rsw_pkg::rsw_axi_rsp_s  axi_rsp
);

    ////////////////////////////////////////////////////////////////
    // declarations
    rsw_pkg::rsw_state_e state_q;
    rsw_pkg::rsw_cause_e cause_q;
    rsw_pkg::rsw_cause_e pend_q;
    logic [7:0]  div_q;
    logic        e_tick;
    logic        running;
    logic [11:0] tick_cnt_q;
    logic        pend_int_q;
    logic [1:0]  rate_q;
    logic        rate_done_q;
    logic [6:0]  win_cnt_q;
    logic        cwe_q;
    logic        inhibit_q;
    logic        cfg_q;
    logic        wd_dis_q;
    logic        mode_q;
    logic        armed_q;
    logic [20:0] wd_cnt_q;
    logic        wd_fire;
    logic        sense, drive_end, gap_end;
    logic [10:0] cm_cnt_q;
    logic        cm_fire;
    logic        wr_take;
    logic        rd_take;
    logic [7:0]  wr_byte;
    logic        awready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        cpu_reset_n_q;
    logic        pin_oe_q;
    logic [15:0] vector_q;

    // watchdog limit for a rate setting
    function automatic logic [20:0] wd_limit(input logic [1:0] rate);
        logic [20:0] base;
        base = 21'(WD_BASE);
        return base << {rate, 1'b0};
    endfunction : wd_limit

    // vector for a cause and mode
    function automatic logic [15:0] pick_vector(
        input rsw_pkg::rsw_cause_e cause,
        input logic                special
    );
        logic [15:0] v;
        v = special ? `RSW_VEC_PIN_S : `RSW_VEC_PIN_N;
        if (cause == rsw_pkg::CAUSE_CM) begin
            v = special ? `RSW_VEC_CM_S : `RSW_VEC_CM_N;
        end else if (cause == rsw_pkg::CAUSE_WD) begin
            v = special ? `RSW_VEC_WD_S : `RSW_VEC_WD_N;
        end
        return v;
    endfunction : pick_vector

    ////////////////////////////////////////////////////////////////
    // bus clock divider
    // E ticks vanish while the clock is halted or too slow
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_q <= 8'h00;
        end else if (div_q == `RSW_E_DIV - 8'h01) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    assign running = (state_q == rsw_pkg::ST_RUN);
    // stop halts E only while the cpu runs
    assign e_tick  = (div_q == 8'h00) && !clock_fail
                   && !(stop_mode && running);
    // reset sensed while running, and step ends
    assign sense     = !rst_pin_i || wd_fire || cm_fire;
    assign drive_end = e_tick && tick_cnt_q == 12'(`RSW_DRIVE_TICKS - 3'd1);
    assign gap_end   = e_tick && tick_cnt_q == 12'(`RSW_GAP_TICKS - 3'd1);

    ////////////////////////////////////////////////////////////////
    // reset sequencer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q    <= rsw_pkg::ST_POR;
            tick_cnt_q <= 12'h000;
        end else begin
            unique case (state_q)
                rsw_pkg::ST_POR: begin
                    if (e_tick) begin
                        tick_cnt_q <= tick_cnt_q + 12'h001;
                    end
                    if (e_tick && tick_cnt_q == `RSW_POR_TICKS - 12'h001) begin
                        state_q <= rsw_pkg::ST_PINWAIT;
                    end
                end
                rsw_pkg::ST_PINWAIT: begin
                    tick_cnt_q <= 12'h000;
                    if (rst_pin_i) begin
                        state_q <= rsw_pkg::ST_RUN;
                    end
                end
                rsw_pkg::ST_DRIVE: begin
                    if (e_tick) begin
                        tick_cnt_q <= tick_cnt_q + 12'h001;
                    end
                    if (drive_end) begin
                        state_q    <= rsw_pkg::ST_GAP;
                        tick_cnt_q <= 12'h000;
                    end
                end
                rsw_pkg::ST_GAP: begin
                    if (e_tick) begin
                        tick_cnt_q <= tick_cnt_q + 12'h001;
                    end
                    if (gap_end) begin
                        tick_cnt_q <= 12'h000;
                        state_q    <= rst_pin_i ? rsw_pkg::ST_RUN : rsw_pkg::ST_PINWAIT;
                    end
                end
                rsw_pkg::ST_RUN: begin
                    tick_cnt_q <= 12'h000;
                    if (sense) begin
                        state_q <= rsw_pkg::ST_DRIVE;
                    end
                end
            endcase
        end
    end

    // pending internal cause, monitor has priority over watchdog
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_int_q <= 1'b0;
            pend_q     <= rsw_pkg::CAUSE_PIN;
        end else if (running) begin
            pend_int_q <= wd_fire || cm_fire;
            pend_q     <= cm_fire ? rsw_pkg::CAUSE_CM : rsw_pkg::CAUSE_WD;
        end
    end

    // cause and vector, fixed at the sample point
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cause_q  <= rsw_pkg::CAUSE_PIN;
            vector_q <= `RSW_VEC_PIN_N;
        end else if (state_q == rsw_pkg::ST_POR) begin
            cause_q  <= rsw_pkg::CAUSE_PIN;
            vector_q <= pick_vector(rsw_pkg::CAUSE_PIN, special_mode);
        end else if (state_q == rsw_pkg::ST_GAP && gap_end) begin
            // low pin at sample means outside reset
            if (!rst_pin_i || !pend_int_q) begin
                cause_q  <= rsw_pkg::CAUSE_PIN;
                vector_q <= pick_vector(rsw_pkg::CAUSE_PIN, special_mode);
            end else begin
                cause_q  <= pend_q;
                vector_q <= pick_vector(pend_q, special_mode);
            end
        end
    end

    // pin drive and cpu hold come straight from flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_oe_q      <= 1'b0;
            cpu_reset_n_q <= 1'b0;
        end else begin
            pin_oe_q      <= running && sense
                             || (state_q == rsw_pkg::ST_DRIVE && !drive_end);
            cpu_reset_n_q <= running && !sense
                             || (state_q == rsw_pkg::ST_PINWAIT && rst_pin_i)
                             || (state_q == rsw_pkg::ST_GAP && rst_pin_i && gap_end);
        end
    end

    ////////////////////////////////////////////////////////////////
    // values latched while the cpu is held in reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd_dis_q  <= 1'b0;
            mode_q    <= 1'b0;
            inhibit_q <= 1'b0;
        end else if (!cpu_reset_n_q) begin
            wd_dis_q  <= cfg_q;
            mode_q    <= special_mode;
            inhibit_q <= special_mode;
        end else if (wr_take && axi_req.awaddr == `RSW_OFS_TEST && axi_req.wstrb[0]) begin
            inhibit_q <= axi_req.wdata[`RSW_TEST_INHIBIT];
        end
    end

    // nonvolatile pending disable, survives internal resets
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= 1'b0;
        end else if (wr_take && axi_req.awaddr == `RSW_OFS_CONFIG && axi_req.wstrb[0]) begin
            cfg_q <= axi_req.wdata[`RSW_CFG_PENDING];
        end
    end

    // rate select and monitor enable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rate_q      <= 2'h0;
            rate_done_q <= 1'b0;
            win_cnt_q   <= 7'h00;
            cwe_q       <= 1'b0;
        end else if (!cpu_reset_n_q) begin
            rate_q      <= 2'h0;
            rate_done_q <= 1'b0;
            win_cnt_q   <= 7'h00;
            cwe_q       <= 1'b0;
        end else begin
            if (e_tick && win_cnt_q != `RSW_RATE_WINDOW) begin
                win_cnt_q <= win_cnt_q + 7'h01;
            end
            if (wr_take && axi_req.awaddr == `RSW_OFS_CTRL && axi_req.wstrb[0]) begin
                cwe_q <= axi_req.wdata[`RSW_CTRL_CWE];
                if (mode_q || (!rate_done_q && win_cnt_q != `RSW_RATE_WINDOW)) begin
                    rate_q      <= axi_req.wdata[`RSW_CTRL_RATE_LO +: 2];
                    rate_done_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // watchdog counter and service sequence
    assign wr_byte = axi_req.wdata[7:0];
    assign wd_fire = running && !wd_dis_q && !inhibit_q
                   && e_tick && wd_cnt_q >= wd_limit(rate_q) - 21'h1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_q <= 21'h000000;
            armed_q  <= 1'b0;
        end else if (!cpu_reset_n_q) begin
            wd_cnt_q <= 21'h000000;
            armed_q  <= 1'b0;
        end else begin
            if (wr_take && axi_req.awaddr == `RSW_OFS_SERVICE && axi_req.wstrb[0]) begin
                // other writes in between leave the arm standing
                if (wr_byte == `RSW_SVC_ARM) begin
                    armed_q <= 1'b1;
                end else if (wr_byte == `RSW_SVC_CLEAR && armed_q) begin
                    armed_q <= 1'b0;
                end
            end
            if (wr_take && axi_req.awaddr == `RSW_OFS_SERVICE && axi_req.wstrb[0]
                && wr_byte == `RSW_SVC_CLEAR && armed_q) begin
                wd_cnt_q <= 21'h000000;
            end else if (e_tick) begin
                // wraps while inhibited too, so enabling never waits for 2^21
                wd_cnt_q <= (wd_cnt_q >= wd_limit(rate_q) - 21'h1) ? 21'h0 : wd_cnt_q + 21'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // clock monitor: counts fast cycles since the last E tick
    // delay sits between the 200 kHz and 10 kHz periods
    assign cm_fire = running && cwe_q
                   && cm_cnt_q == 11'(`RSW_CM_CYCLES - 1);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cm_cnt_q <= 11'h000;
        end else if (e_tick || !cwe_q || !running || cm_fire) begin
            cm_cnt_q <= 11'h000;
        end else begin
            cm_cnt_q <= cm_cnt_q + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi4-lite write: address and data taken together
    assign wr_take = awready_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RSW_RESP_OKAY;
        end else begin
            awready_q <= axi_req.awvalid && axi_req.wvalid && !awready_q && !bvalid_q;
            if (awready_q) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (axi_req.awaddr inside {`RSW_OFS_CTRL, `RSW_OFS_SERVICE, `RSW_OFS_TEST, `RSW_OFS_CONFIG})
                          ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
            end else if (axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // axi4-lite read
    assign rd_take = arready_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RSW_RESP_OKAY;
        end else begin
            arready_q <= axi_req.arvalid && !arready_q && !rvalid_q;
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rresp_q  <= `RSW_RESP_OKAY;
                rdata_q  <= 32'h00000000;
                unique case (axi_req.araddr)
                    `RSW_OFS_CTRL: begin
                        rdata_q[`RSW_CTRL_RATE_LO +: 2] <= rate_q;
                        rdata_q[`RSW_CTRL_CWE]         <= cwe_q;
                    end
                    `RSW_OFS_TEST: begin
                        rdata_q[`RSW_TEST_INHIBIT] <= inhibit_q;
                    end
                    `RSW_OFS_CONFIG: begin
                        rdata_q[`RSW_CFG_PENDING] <= cfg_q;
                        rdata_q[`RSW_CFG_ACTIVE]  <= wd_dis_q;
                    end
                    `RSW_OFS_STATUS: begin
                        rdata_q[1:0]   <= cause_q;
                        rdata_q[2]     <= mode_q;
                        rdata_q[3]     <= armed_q;
                        rdata_q[31:16] <= vector_q;
                    end
                    `RSW_OFS_SERVICE: begin
                        rdata_q <= 32'h00000000; // write only
                    end
                    default: begin
                        rresp_q <= `RSW_RESP_SLVERR;
                    end
                endcase
            end else if (axi_req.rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign rst_pin_o        = 1'b0;
    assign rst_pin_oe       = pin_oe_q;
    assign cpu_reset_n      = cpu_reset_n_q;
    assign start_vector     = vector_q;
    assign axi_rsp.awready  = awready_q;
    assign axi_rsp.wready   = awready_q;
    assign axi_rsp.bvalid   = bvalid_q;
    assign axi_rsp.bresp    = bresp_q;
    assign axi_rsp.arready  = arready_q;
    assign axi_rsp.rvalid   = rvalid_q;
    assign axi_rsp.rdata    = rdata_q;
    assign axi_rsp.rresp    = rresp_q;

endmodule : rsw_reset_ctl

`default_nettype wire

/* File: rsw_params.svh */
// constants for the reset source and watchdog block
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// register byte offsets
`define RSW_OFS_CTRL     8'h00
`define RSW_OFS_SERVICE  8'h04
`define RSW_OFS_TEST     8'h08
`define RSW_OFS_CONFIG   8'h0C
`define RSW_OFS_STATUS   8'h10

// field positions
`define RSW_CTRL_RATE_LO 0
`define RSW_CTRL_CWE     3
`define RSW_TEST_INHIBIT 0
`define RSW_CFG_PENDING  0
`define RSW_CFG_ACTIVE   1

// service sequence codes
`define RSW_SVC_ARM      8'h55
`define RSW_SVC_CLEAR    8'hAA

// reset vectors, normal and special modes
`define RSW_VEC_PIN_N    16'hFFFE
`define RSW_VEC_CM_N     16'hFFFC
`define RSW_VEC_WD_N     16'hFFFA
`define RSW_VEC_PIN_S    16'hBFFE
`define RSW_VEC_CM_S     16'hBFFC
`define RSW_VEC_WD_S     16'hBFFA

// timing, in bus clock (E) ticks unless named otherwise
`define RSW_E_DIV        8'd4
`define RSW_POR_TICKS    12'd4064
`define RSW_DRIVE_TICKS  3'd4
`define RSW_GAP_TICKS    3'd2
`define RSW_RATE_WINDOW  7'd64
`define RSW_WD_BASE      32768
`define RSW_CLK_NS       10
`define RSW_CM_DELAY_NS  20000
`define RSW_CM_CYCLES    (`RSW_CM_DELAY_NS / `RSW_CLK_NS)

// axi answers
`define RSW_RESP_OKAY    2'h0
`define RSW_RESP_SLVERR  2'h2

`endif

/* File: rsw_pkg.sv */
// types for the reset source and watchdog block
package rsw_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ST_POR,
        ST_PINWAIT,
        ST_DRIVE,
        ST_GAP,
        ST_RUN
    } rsw_state_e;

    // reset cause as reported
    typedef enum logic [1:0] {
        CAUSE_PIN,
        CAUSE_CM,
        CAUSE_WD
    } rsw_cause_e;

    // axi4-lite master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } rsw_axi_req_s;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rsw_axi_rsp_s;

endpackage : rsw_pkg

/* File: rsw_props.sv */
// assertion checker for the reset sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "rsw_params.svh"
module rsw_props #(
    parameter int WD_BASE = `RSW_WD_BASE
) (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  resetn,
    // pin and cpu side
    input wire logic                  rst_pin_i,
    input wire logic                  rst_pin_o,
    input wire logic                  rst_pin_oe,
    input wire logic                  special_mode,
    input wire logic                  stop_mode,
    input wire logic                  clock_fail,
    input wire logic                  cpu_reset_n,
    input wire logic [15:0]           start_vector,
    // register bus
    input wire rsw_pkg::rsw_axi_req_s axi_req,
    input wire rsw_pkg::rsw_axi_rsp_s axi_rsp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [14:0] por_q;
    logic [4:0]  oe_q;
    logic [3:0]  rel_q;
    ////////////////////////////////////////////////////////////
    // clocks since power-on release, saturating
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) por_q <= 15'h0;
        else if (por_q != 15'h7FFF) por_q <= por_q + 15'h1;
    end
    // length of the current pin pull
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) oe_q <= 5'h0;
        else oe_q <= rst_pin_oe ? oe_q + 5'h1 : 5'h0;
    end
    // clocks since the pin was let go; starts saturated
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rel_q <= 4'hF;
        else if (rst_pin_oe) rel_q <= 4'h0;
        else if (rel_q != 4'hF) rel_q <= rel_q + 4'h1;
    end
    ////////////////////////////////////////////////////////////
    por_hold_a: assert property (cpu_reset_n |-> por_q >= 15'h3F7A) else $error("cpu left reset early");
    pin_hold_a: assert property (!cpu_reset_n && !rst_pin_i |=> !cpu_reset_n) else $error("reset ended, pin low");
    ext_rst_a: assert property (cpu_reset_n && !rst_pin_i |=> !cpu_reset_n) else $error("pin reset missed");
    pull_len_a: assert property ($fell(rst_pin_oe) |-> oe_q inside {[5'h0D:5'h11]}) else $error("pull length");
    pull_start_a: assert property ($fell(cpu_reset_n) |-> ##[0:1] rst_pin_oe) else $error("no pin pull");
    odrain_a: assert property (!rst_pin_o && !(cpu_reset_n && rst_pin_oe)) else $error("pin drive wrong");
    sample_gap_a: assert property ($rose(cpu_reset_n) |-> rel_q >= 4'h5) else $error("pin sampled early");
    vec_set_a: assert property (cpu_reset_n |-> start_vector inside {`RSW_VEC_PIN_N, `RSW_VEC_CM_N,
        `RSW_VEC_WD_N, `RSW_VEC_PIN_S, `RSW_VEC_CM_S, `RSW_VEC_WD_S}) else $error("bad vector");
    vec_hold_a: assert property (cpu_reset_n && $past(cpu_reset_n) |-> $stable(start_vector))
        else $error("vector moved");
    b_stand_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("bvalid dropped");
    r_stand_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("rvalid dropped");
    // main scenarios
    c_pull: cover property ($rose(rst_pin_oe));
    c_wd: cover property ($rose(cpu_reset_n) && start_vector == `RSW_VEC_WD_N);
    c_cm: cover property ($rose(cpu_reset_n) && start_vector == `RSW_VEC_CM_N);
    c_err: cover property (axi_rsp.rvalid && axi_rsp.rresp == `RSW_RESP_SLVERR);
endmodule : rsw_props
bind rsw_reset_ctl rsw_props #(.WD_BASE(WD_BASE)) u_props (.*);
`default_nettype wire

/* File: rsw_pin_model.sv */
// external reset circuit on the open-drain pin
`timescale 1ns/100ps
`default_nettype none
module rsw_pin_model (
    // device side
    input wire logic  dev_o,
    input wire logic  dev_oe,
    // board side
    input wire logic  ext_low,
    output logic      pin
);
    // pull-up wins unless someone pulls low; board holds low past delay
    assign pin = (dev_oe ? dev_o : 1'b1) & ~ext_low;
endmodule : rsw_pin_model
`default_nettype wire

/* File: rsw_reset_ctl_tb.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
`include "rsw_params.svh"
module rsw_reset_ctl_tb;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } rsw_note_s;
    logic                  clock, resetn, ext_low, special_mode, stop_mode, clock_fail;
    logic                  pin, pin_o, pin_oe, cpu_reset_n;
    logic [15:0]           start_vector;
    logic [31:0]           junk;
    rsw_pkg::rsw_axi_req_s req;
    rsw_pkg::rsw_axi_rsp_s rsp;
    rsw_note_s             rq[$];
    rsw_note_s             note;
    logic [1:0]            wq[$];
    int                    bad_count = 0, check_count = 0, cyc = 0;
    ////////////////////////////////////////////////////////////
    rsw_reset_ctl #(.WD_BASE(64)) dut (.clock(clock), .resetn(resetn), .rst_pin_i(pin), .rst_pin_o(pin_o),
        .rst_pin_oe(pin_oe), .special_mode(special_mode), .stop_mode(stop_mode), .clock_fail(clock_fail),
        .cpu_reset_n(cpu_reset_n), .start_vector(start_vector), .axi_req(req), .axi_rsp(rsp));
    rsw_pin_model u_pin (.dev_o(pin_o), .dev_oe(pin_oe), .ext_low(ext_low), .pin(pin));
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : check_val
    // write: address and data together, bready up until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        do @(posedge clock); while (rsp.awready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge clock); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        rq.push_back('{d, m, r});
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(posedge clock); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clock); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
    endtask : axi_rd
    // bounded wait for a cpu reset level, sampled mid-cycle
    task automatic wait_rst(input logic lv, input int lim);
        int i = 0;
        while (cpu_reset_n !== lv && i < lim) begin
            @(negedge clock);
            i++;
        end
        check_val("cpu_reset_n", {31'h0, lv}, {31'h0, cpu_reset_n});
    endtask : wait_rst
    // board pulls the pin for a while; special level latched meanwhile
    task automatic pin_reset(input logic sp);
        @(posedge clock);
        ext_low <= 1'b1;
        special_mode <= sp;
        wait_rst(1'b0, 20);
        repeat (40) @(negedge clock);
        ext_low <= 1'b0;
        wait_rst(1'b1, 100);
    endtask : pin_reset
    ////////////////////////////////////////////////////////////
    // read notes taken oldest first as answers appear
    always @(posedge clock) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            note = rq.pop_front();
            check_val("rdata", note.d, rsp.rdata & note.m);
            check_val("rresp", {30'h0, note.r}, {30'h0, rsp.rresp});
        end
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1) check_val("bresp", {30'h0, wq.pop_front()}, {30'h0, rsp.bresp});
    end
    // hang guard, well above the planned run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        ext_low = 1'b1;
        special_mode = 1'b0;
        stop_mode = 1'b0;
        clock_fail = 1'b0;
        req = '0;
        junk = $urandom(32'h2b1d6509);
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (16200) @(negedge clock);
        wait_rst(1'b0, 0);
        repeat (300) @(negedge clock);
        wait_rst(1'b0, 0);
        ext_low <= 1'b0;
        wait_rst(1'b1, 20);
        check_val("vector", {16'h0, `RSW_VEC_PIN_N}, {16'h0, start_vector});
        axi_rd(`RSW_OFS_CTRL, 32'h0, 32'hF, `RSW_RESP_OKAY);
        axi_wr(`RSW_OFS_CTRL, 32'h1, `RSW_RESP_OKAY);
        axi_wr(`RSW_OFS_CTRL, 32'h2, `RSW_RESP_OKAY);
        axi_rd(`RSW_OFS_CTRL, 32'h1, 32'hF, `RSW_RESP_OKAY);
        axi_wr(8'h20, junk, `RSW_RESP_SLVERR);
        axi_rd(8'h20, 32'h0, 32'h0, `RSW_RESP_SLVERR);
        axi_wr(`RSW_OFS_STATUS, junk, `RSW_RESP_SLVERR);
        // service well past three timeouts, junk between the two writes
        repeat (6) begin
            junk = $urandom();
            if (junk[7:0] inside {8'h55, 8'hAA}) junk[0] = ~junk[0];
            axi_wr(`RSW_OFS_SERVICE, 32'h55, `RSW_RESP_OKAY);
            axi_wr(`RSW_OFS_SERVICE, junk, `RSW_RESP_OKAY);
            axi_rd(`RSW_OFS_STATUS, 32'h8, 32'h8, `RSW_RESP_OKAY);
            axi_wr(`RSW_OFS_SERVICE, 32'hAA, `RSW_RESP_OKAY);
            repeat (600) @(negedge clock);
        end
        wait_rst(1'b1, 0);
        wait_rst(1'b0, 1100);
        wait_rst(1'b1, 100);
        axi_rd(`RSW_OFS_STATUS, {`RSW_VEC_WD_N, 16'h2}, 32'hFFFF000B, `RSW_RESP_OKAY);
        axi_wr(`RSW_OFS_CTRL, 32'h8, `RSW_RESP_OKAY);
        axi_rd(`RSW_OFS_CTRL, 32'h8, 32'hF, `RSW_RESP_OKAY);
        @(posedge clock);
        clock_fail <= 1'b1;
        wait_rst(1'b0, 2100);
        clock_fail <= 1'b0;
        wait_rst(1'b1, 100);
        axi_rd(`RSW_OFS_STATUS, {`RSW_VEC_CM_N, 16'h1}, 32'hFFFF0003, `RSW_RESP_OKAY);
        axi_rd(`RSW_OFS_CTRL, 32'h0, 32'hF, `RSW_RESP_OKAY);
        pin_reset(1'b1);
        check_val("vector", {16'h0, `RSW_VEC_PIN_S}, {16'h0, start_vector});
        repeat (800) @(negedge clock);
        wait_rst(1'b1, 0);
        axi_wr(`RSW_OFS_TEST, 32'h0, `RSW_RESP_OKAY);
        wait_rst(1'b0, 400);
        wait_rst(1'b1, 100);
        check_val("vector", {16'h0, `RSW_VEC_WD_S}, {16'h0, start_vector});
        axi_wr(`RSW_OFS_CONFIG, 32'h1, `RSW_RESP_OKAY);
        axi_rd(`RSW_OFS_CONFIG, 32'h1, 32'h3, `RSW_RESP_OKAY);
        pin_reset(1'b0);
        axi_rd(`RSW_OFS_CONFIG, 32'h3, 32'h3, `RSW_RESP_OKAY);
        repeat (800) @(negedge clock);
        wait_rst(1'b1, 0);
        print_verdict();
    end
endmodule : rsw_reset_ctl_tb
`default_nettype wire
